/* hdl/cvs_pkg.sv */
// Constants for the charge voltage and current setpoint register bank.
package cvs_pkg;
   // Command codes of the registers.
   localparam logic [7:0]  CMD_CHARGE_OPTION     = 8'h12;
   localparam logic [7:0]  CMD_CHARGE_CURRENT    = 8'h14;
   localparam logic [7:0]  CMD_MAX_CHARGE_VOLT   = 8'h15;
   localparam logic [7:0]  CMD_MIN_SYSTEM_VOLT   = 8'h3e;
   // Field layouts.
   localparam int          LDO_EN_BIT            = 2;
   localparam logic [15:0] ICHG_FIELD_MASK       = 16'h1fc0;
   localparam logic [15:0] ICHG_INVALID_MASK     = 16'he000;
   localparam logic [15:0] VCHG_FIELD_MASK       = 16'h7ff0;
   localparam logic [15:0] VCHG_INVALID_MASK     = 16'h8000;
   localparam logic [15:0] VSYS_FIELD_MASK       = 16'h3f00;
   localparam logic [15:0] VSYS_INVALID_MASK     = 16'hc000;
   // Legal ranges in mV.
   localparam logic [15:0] VCHG_MIN_MV           = 16'h0400;
   localparam logic [15:0] VCHG_MAX_MV           = 16'h4b00;
   localparam logic [15:0] VSYS_MIN_MV           = 16'h0400;
   localparam logic [15:0] VSYS_MAX_MV           = 16'h3f00;
   // Reset values.
   localparam logic [15:0] ICHG_RESET            = 16'h0000;
   localparam logic        LDO_EN_RESET          = 1'b1;
   // Defaults by cell count, in mV.
   localparam logic [15:0] VCHG_DEF_1S           = 16'h1060;
   localparam logic [15:0] VCHG_DEF_2S           = 16'h20d0;
   localparam logic [15:0] VCHG_DEF_3S           = 16'h3130;
   localparam logic [15:0] VCHG_DEF_4S           = 16'h41a0;
   localparam logic [15:0] VSYS_DEF_1S           = 16'h0e00;
   localparam logic [15:0] VSYS_DEF_2S           = 16'h1800;
   localparam logic [15:0] VSYS_DEF_3S           = 16'h2400;
   localparam logic [15:0] VSYS_DEF_4S           = 16'h3000;
   // Charge clamps in mA and thresholds in mV.
   localparam logic [15:0] PRECHG_CLAMP_MA       = 16'h0180;
   localparam logic [15:0] LDO_FAST_CLAMP_MA     = 16'h07d0;
   localparam logic [15:0] ONE_CELL_PRECHG_MV    = 16'h0bb8;
   // Strap codes and settle count after reset.
   localparam logic [2:0]  STRAP_ABSENT          = 3'h0;
   localparam logic [2:0]  STRAP_ONE_CELL        = 3'h1;
   localparam logic [2:0]  STRAP_TWO_CELL        = 3'h2;
   localparam logic [2:0]  STRAP_THREE_CELL      = 3'h3;
   localparam logic [2:0]  STRAP_FOUR_CELL       = 3'h4;
   localparam logic [1:0]  STRAP_SETTLE_CYCLES   = 2'h3;
endpackage : cvs_pkg

/* hdl/cvs_setpoints.sv */
// Charge current, charge voltage and minimum system voltage setpoint registers.
`timescale 1ns/1ps

// Function
// RL1: Charge-current bit 7 weighs 128 mA, bit 6 64 mA; bits 5-0 ignored.
// RL2: Charge-current bits 12-8 weigh 4096 to 256 mA; bits 15-13 set invalidates write.
// RL3: Battery removal on the strap clears the charge-current setting.
// RL4: Linear regulation mode during pre-charge, enabled by a config bit resetting to one.
// RL5: Two to four cells: regulate at minimum system voltage, pre-charge clamp 384 mA.
// RL6: One cell: pre-charge ends at 3 V, pre-charge clamp 384 mA.
// RL7: One cell between 3 V and minimum system voltage: linear mode, 2 A clamp.
// RL8: Charge voltage covers 1.024 V to 19.200 V in 16 mV steps.
// RL9: Charge-voltage writes outside 1.024 V to 19.200 V are discarded.
// RL10: Charge-voltage power-on default 4192, 8400, 12592 or 16800 mV by cell count.
// RL11: With power good, a current write starts charging at once.
// RL12: Host writes charge voltage before current when cell voltage is not 4.2 V.
// RL13: Writing zero to charge voltage restores its default and zeroes charge current.
// RL14: Charge-voltage field is bits 14-4, binary from 16384 mV to 16 mV.
// RL15: Charge-voltage write with bit 15 set is invalid.
// RL16: Charge-voltage bits 3-0 never affect the setpoint.
// RL17: Minimum system voltage spans 1.024 V to 16.128 V in 256 mV steps.
// RL18: Minimum system voltage writes outside range are ignored.
// RL19: Minimum system voltage default 3.584, 6.144, 9.216 or 12.288 V by cells.
// RL20: Minimum system voltage field is bits 13-8, 8192 to 256 mV; bits 7-0 ignored.
// RL21: Strap is sampled after reset and selects both voltage defaults.
module cvs_setpoints (
   // Clock and reset.
   input  wire logic        i_mclk,
   input  wire logic        i_resetn,
   // Register command port.
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_cmd,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   // Pins.
   input  wire logic [2:0]  i_cell_count_battery_present_strap,
   input  wire logic        i_input_power_good,
   // Analog loop side.
   input  wire logic [15:0] i_battery_voltage_mv,
   output logic      [15:0] o_charge_current_ma,
   output logic      [15:0] o_max_charge_voltage_mv,
   output logic      [15:0] o_min_system_voltage_mv,
   output logic             o_charge_enable,
   output logic             o_precharge,
   output logic             o_linear_regulation_mode
);

   typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} cvs_init_e;

   cvs_init_e   init_state_ff;
   logic [1:0]  settle_cnt_ff;
   logic [2:0]  strap_s1_ff, strap_s2_ff, strap_s3_ff;
   logic [2:0]  strap_ff;
   logic [2:0]  cells_ff;
   logic        pg_s1_ff, pg_s2_ff, pg_s3_ff, pg_ff;
   logic [15:0] ichg_ff, vchg_ff, vsys_ff;
   logic        ldo_en_ff;
   logic        charge_en_ff;
   logic [15:0] rdata_ff;
   logic [15:0] ichg_out_ff;
   logic        precharge_ff, linear_ff;
   logic [15:0] vchg_def, vsys_def;
   logic [15:0] vchg_wr, vsys_wr;
   logic        wr_ichg, wr_vchg, wr_vsys, wr_opt;
   logic        ichg_ok, vchg_zero, vchg_ok, vsys_ok;
   logic        battery_removed;
   logic        one_cell;
   logic [15:0] nxt_ichg_out;
   logic        nxt_precharge, nxt_linear;

   // Pin synchronisers; a change counts once stages two and three agree.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         strap_s1_ff <= 3'h0;
         strap_s2_ff <= 3'h0;
         strap_s3_ff <= 3'h0;
         pg_s1_ff    <= 1'b0;
         pg_s2_ff    <= 1'b0;
         pg_s3_ff    <= 1'b0;
      end else begin
         strap_s1_ff <= i_cell_count_battery_present_strap;
         strap_s2_ff <= strap_s1_ff;
         strap_s3_ff <= strap_s2_ff;
         pg_s1_ff    <= i_input_power_good;
         pg_s2_ff    <= pg_s1_ff;
         pg_s3_ff    <= pg_s2_ff;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         strap_ff <= cvs_pkg::STRAP_ABSENT;
         pg_ff    <= 1'b0;
      end else begin
         if (strap_s2_ff == strap_s3_ff) begin
            strap_ff <= strap_s3_ff;
         end
         if (pg_s2_ff == pg_s3_ff) begin
            pg_ff <= pg_s3_ff;
         end
      end
   end

   // Battery removal is the filtered strap going to the absent code.
   assign battery_removed = (init_state_ff == ST_RUN) && (strap_ff == cvs_pkg::STRAP_ABSENT);

   // RL21: strap capture after reset.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         init_state_ff <= ST_SETTLE;
         settle_cnt_ff <= 2'h0;
         cells_ff      <= cvs_pkg::STRAP_ONE_CELL;
      end else begin
         case (init_state_ff)
            ST_SETTLE: begin
               settle_cnt_ff <= settle_cnt_ff + 2'h1;
               if (settle_cnt_ff == cvs_pkg::STRAP_SETTLE_CYCLES) begin
                  init_state_ff <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               cells_ff      <= strap_ff;
               init_state_ff <= ST_RUN;
            end
            ST_RUN: begin
               init_state_ff <= ST_RUN;
            end
            default: begin
               init_state_ff <= ST_SETTLE;
            end
         endcase
      end
   end

   // RL10: charge voltage default by cells.
   // RL19: system voltage default by cells.
   always_comb begin
      case (init_state_ff == ST_LOAD ? strap_ff : cells_ff)
         cvs_pkg::STRAP_TWO_CELL: begin
            vchg_def = cvs_pkg::VCHG_DEF_2S;
            vsys_def = cvs_pkg::VSYS_DEF_2S;
         end
         cvs_pkg::STRAP_THREE_CELL: begin
            vchg_def = cvs_pkg::VCHG_DEF_3S;
            vsys_def = cvs_pkg::VSYS_DEF_3S;
         end
         cvs_pkg::STRAP_FOUR_CELL: begin
            vchg_def = cvs_pkg::VCHG_DEF_4S;
            vsys_def = cvs_pkg::VSYS_DEF_4S;
         end
         default: begin
            vchg_def = cvs_pkg::VCHG_DEF_1S;
            vsys_def = cvs_pkg::VSYS_DEF_1S;
         end
      endcase
   end

   assign wr_ichg = i_reg_wr && (i_reg_cmd == cvs_pkg::CMD_CHARGE_CURRENT);
   assign wr_vchg = i_reg_wr && (i_reg_cmd == cvs_pkg::CMD_MAX_CHARGE_VOLT);
   assign wr_vsys = i_reg_wr && (i_reg_cmd == cvs_pkg::CMD_MIN_SYSTEM_VOLT);
   assign wr_opt  = i_reg_wr && (i_reg_cmd == cvs_pkg::CMD_CHARGE_OPTION);

   // RL16: low reserved bits dropped.
   assign vchg_wr   = i_reg_wdata & cvs_pkg::VCHG_FIELD_MASK;
   assign vsys_wr   = i_reg_wdata & cvs_pkg::VSYS_FIELD_MASK;
   // RL2: upper current bits invalidate.
   assign ichg_ok   = (i_reg_wdata & cvs_pkg::ICHG_INVALID_MASK) == 16'h0000;
   // RL15: reserved bit 15 invalidates.
   assign vchg_zero = ((i_reg_wdata & cvs_pkg::VCHG_INVALID_MASK) == 16'h0000) && (vchg_wr == 16'h0000);
   // RL9: range check on charge voltage.
   assign vchg_ok   = ((i_reg_wdata & cvs_pkg::VCHG_INVALID_MASK) == 16'h0000)
                      && (vchg_wr >= cvs_pkg::VCHG_MIN_MV) && (vchg_wr <= cvs_pkg::VCHG_MAX_MV);
   // RL18: range check on system voltage.
   assign vsys_ok   = ((i_reg_wdata & cvs_pkg::VSYS_INVALID_MASK) == 16'h0000)
                      && (vsys_wr >= cvs_pkg::VSYS_MIN_MV) && (vsys_wr <= cvs_pkg::VSYS_MAX_MV);

   // RL1: charge current field kept.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         ichg_ff <= cvs_pkg::ICHG_RESET;
      end else if (battery_removed || (wr_vchg && vchg_zero)) begin
         // RL3: removal clears current.
         // RL13: zero voltage write clears current.
         ichg_ff <= cvs_pkg::ICHG_RESET;
      end else if (wr_ichg && ichg_ok) begin
         ichg_ff <= i_reg_wdata & cvs_pkg::ICHG_FIELD_MASK;
      end
   end

   // RL8: charge voltage register.
   // RL14: field is bits 14-4.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         vchg_ff <= cvs_pkg::VCHG_DEF_1S;
      end else if (init_state_ff == ST_LOAD || (wr_vchg && vchg_zero)) begin
         vchg_ff <= vchg_def;
      end else if (wr_vchg && vchg_ok) begin
         vchg_ff <= vchg_wr;
      end
   end

   // RL17: system voltage register.
   // RL20: field is bits 13-8.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         vsys_ff <= cvs_pkg::VSYS_DEF_1S;
      end else if (init_state_ff == ST_LOAD) begin
         vsys_ff <= vsys_def;
      end else if (wr_vsys && vsys_ok) begin
         vsys_ff <= vsys_wr;
      end
   end

   // RL4: linear mode enable bit.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         ldo_en_ff <= cvs_pkg::LDO_EN_RESET;
      end else if (wr_opt) begin
         ldo_en_ff <= i_reg_wdata[cvs_pkg::LDO_EN_BIT];
      end
   end

   // RL11: current write starts charging.
   // RL12: no voltage write needed first.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         charge_en_ff <= 1'b0;
      end else if (!pg_ff || battery_removed || (wr_vchg && vchg_zero)) begin
         charge_en_ff <= 1'b0;
      end else if (wr_ichg && ichg_ok) begin
         charge_en_ff <= (i_reg_wdata & cvs_pkg::ICHG_FIELD_MASK) != 16'h0000;
      end
   end

   assign one_cell = (cells_ff == cvs_pkg::STRAP_ONE_CELL);

   // Pre-charge phase, linear mode and current clamp.
   always_comb begin
      nxt_ichg_out = ichg_ff;
      nxt_linear   = 1'b0;
      // RL6: one cell pre-charge below 3 V.
      // RL5: multi-cell pre-charge below system minimum.
      if (one_cell) begin
         nxt_precharge = i_battery_voltage_mv < cvs_pkg::ONE_CELL_PRECHG_MV;
      end else begin
         nxt_precharge = i_battery_voltage_mv < vsys_ff;
      end
      if (ldo_en_ff && (i_battery_voltage_mv < vsys_ff)) begin
         nxt_linear = 1'b1;
      end
      if (nxt_precharge && (ichg_ff > cvs_pkg::PRECHG_CLAMP_MA)) begin
         nxt_ichg_out = cvs_pkg::PRECHG_CLAMP_MA;
      end else if (!nxt_precharge && nxt_linear && one_cell && (ichg_ff > cvs_pkg::LDO_FAST_CLAMP_MA)) begin
         // RL7: one cell fast charge clamp.
         nxt_ichg_out = cvs_pkg::LDO_FAST_CLAMP_MA;
      end
      if (!charge_en_ff) begin
         nxt_ichg_out = 16'h0000;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         ichg_out_ff  <= 16'h0000;
         precharge_ff <= 1'b0;
         linear_ff    <= 1'b0;
      end else begin
         ichg_out_ff  <= nxt_ichg_out;
         precharge_ff <= nxt_precharge;
         linear_ff    <= nxt_linear;
      end
   end

   // Read data is captured on the read strobe; unmapped codes read zero.
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         rdata_ff <= 16'h0000;
      end else if (i_reg_rd) begin
         case (i_reg_cmd)
            cvs_pkg::CMD_CHARGE_CURRENT:  rdata_ff <= ichg_ff;
            cvs_pkg::CMD_MAX_CHARGE_VOLT: rdata_ff <= vchg_ff;
            cvs_pkg::CMD_MIN_SYSTEM_VOLT: rdata_ff <= vsys_ff;
            cvs_pkg::CMD_CHARGE_OPTION:   rdata_ff <= {13'h0, ldo_en_ff, 2'h0};
            default:                      rdata_ff <= 16'h0000;
         endcase
      end
   end

   assign o_reg_rdata              = rdata_ff;
   assign o_charge_current_ma      = ichg_out_ff;
   assign o_max_charge_voltage_mv  = vchg_ff;
   assign o_min_system_voltage_mv  = vsys_ff;
   assign o_charge_enable          = charge_en_ff;
   assign o_precharge              = precharge_ff;
   assign o_linear_regulation_mode = linear_ff;

   sequence s_bad_vchg;
      wr_vchg && !vchg_ok && !vchg_zero && init_state_ff == ST_RUN;
   endsequence

   a_vchg_range_drop: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL9
      s_bad_vchg |=> $stable(vchg_ff)) else $error("Out of range charge voltage write was stored.");

   a_vchg_zero_reset: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL13
      (wr_vchg && vchg_zero) |=> (vchg_ff == vchg_def) && (ichg_ff == 16'h0000) && !charge_en_ff)
      else $error("Zero voltage write did not restore default and clear current.");

   a_vchg_field_bits: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL16
      (vchg_ff & ~cvs_pkg::VCHG_FIELD_MASK) == 16'h0000) else $error("Charge voltage holds reserved bits.");

   a_vchg_in_range: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL8
      vchg_ff >= cvs_pkg::VCHG_MIN_MV && vchg_ff <= cvs_pkg::VCHG_MAX_MV)
      else $error("Charge voltage out of range.");

   a_vsys_range_drop: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL18
      (wr_vsys && !vsys_ok && init_state_ff == ST_RUN) |=> $stable(vsys_ff))
      else $error("Out of range system voltage write was stored.");

   a_ichg_invalid_drop: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL2
      (wr_ichg && !ichg_ok && !battery_removed && !wr_vchg) |=> $stable(ichg_ff))
      else $error("Invalid current write was stored.");

   a_removal_clears: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL3
      battery_removed |=> (ichg_ff == 16'h0000) ##1 (o_charge_current_ma == 16'h0000))
      else $error("Battery removal did not clear charge current.");

   a_start_on_write: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL11
      (wr_ichg && ichg_ok && pg_ff && !battery_removed && !wr_vchg
       && (i_reg_wdata & cvs_pkg::ICHG_FIELD_MASK) != 16'h0000) |=> charge_en_ff)
      else $error("Current write with power good did not start charging.");

   a_power_loss_stop: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL11
      !pg_ff |=> !charge_en_ff) else $error("Charging stayed on without input power.");

   a_precharge_clamp: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL5
      o_precharge |-> o_charge_current_ma <= cvs_pkg::PRECHG_CLAMP_MA)
      else $error("Pre-charge current above clamp.");

   a_defaults_load: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RL19
      (init_state_ff == ST_LOAD) |=> (vsys_ff == vsys_def) && (vchg_ff == vchg_def))
      else $error("Cell count defaults not loaded.");

endmodule // cvs_setpoints

/* testbench/cvs_host_model.sv */
// Host controller model that issues register writes and reads.
`timescale 1ns/1ps
module cvs_host_model (
   // Clock.
   input  wire logic        i_mclk,
   // Register command port.
   output logic             o_reg_wr,
   output logic             o_reg_rd,
   output logic      [7:0]  o_reg_cmd,
   output logic      [15:0] o_reg_wdata,
   input  wire logic [15:0] i_reg_rdata
);
   initial begin
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_cmd   = 8'h00;
      o_reg_wdata = 16'h0000;
   end

   // Idle command and data lines invert so that a stale value is never mistaken for a request.
   task automatic release_bus();
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_cmd   = ~o_reg_cmd;
      o_reg_wdata = ~o_reg_wdata;
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      @(negedge i_mclk);
      o_reg_wr    = 1'b1;
      o_reg_cmd   = cmd;
      o_reg_wdata = data;
      @(negedge i_mclk);
      release_bus();
   endtask

   task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
      @(negedge i_mclk);
      o_reg_rd  = 1'b1;
      o_reg_cmd = cmd;
      @(negedge i_mclk);
      release_bus();
      @(negedge i_mclk);
      data = i_reg_rdata;
   endtask

   task automatic set_charge(input logic [15:0] vchg, input logic [15:0] ichg);
      wr(cvs_pkg::CMD_MAX_CHARGE_VOLT, vchg);
      wr(cvs_pkg::CMD_CHARGE_CURRENT, ichg);
   endtask
endmodule // cvs_host_model

/* testbench/cvs_setpoints_test.sv */
// Self-checking testbench for the charge setpoint register bank.
`timescale 1ns/1ps
module cvs_setpoints_test;
   localparam logic [0:3][15:0] VCHG_DEF = {16'h1060, 16'h20d0, 16'h3130, 16'h41a0};
   localparam logic [0:3][15:0] VSYS_DEF = {16'h0e00, 16'h1800, 16'h2400, 16'h3000};
   localparam logic [0:6][15:0] VW       = {16'h20d5, 16'h03f0, 16'h4b10, 16'h4b00, 16'h8400, 16'h0400, 16'h8000};
   localparam logic [0:6][15:0] VE       = {16'h20d0, 16'h20d0, 16'h20d0, 16'h4b00, 16'h4b00, 16'h0400, 16'h0400};
   localparam logic [0:4][15:0] SW       = {16'h3fff, 16'h4000, 16'h03ff, 16'h0400, 16'h10aa};
   localparam logic [0:4][15:0] SE       = {16'h3f00, 16'h3f00, 16'h3f00, 16'h0400, 16'h1000};
   logic        i_mclk    = 1'b0;
   logic        i_resetn  = 1'b0;
   logic [2:0]  strap     = 3'h1;
   logic        pgood     = 1'b1;
   logic [15:0] vbat      = 16'h1000;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_cmd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [15:0] ichg_ma;
   logic [15:0] vchg_mv;
   logic [15:0] vsys_mv;
   logic        chg_en;
   logic        prechg;
   logic        linear;
   int          err_count = 0;
   int          checked   = 0;
   int          cycles    = 0;

   always #12.5 i_mclk = ~i_mclk;

   cvs_setpoints u_dut (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_cmd(reg_cmd),
      .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_cell_count_battery_present_strap(strap),
      .i_input_power_good(pgood), .i_battery_voltage_mv(vbat), .o_charge_current_ma(ichg_ma),
      .o_max_charge_voltage_mv(vchg_mv), .o_min_system_voltage_mv(vsys_mv), .o_charge_enable(chg_en),
      .o_precharge(prechg), .o_linear_regulation_mode(linear));

   cvs_host_model u_host (
      .i_mclk(i_mclk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_cmd(reg_cmd), .o_reg_wdata(reg_wdata),
      .i_reg_rdata(reg_rdata));

   task automatic test_done();
      $display("Checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   task automatic por(input logic [2:0] cells);
      @(negedge i_mclk);
      strap    = cells;
      i_resetn = 1'b0;
      cyc(20);
      i_resetn = 1'b1;
      cyc(10);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] d;
      u_host.rd(cmd, d);
      chk(name, d, exp);
   endtask

   task automatic flags(input logic [15:0] ma, input logic pc, input logic lin);
      cyc(4);
      chk("charge_current_out", ichg_ma, ma);
      chk("precharge", {15'h0, prechg}, {15'h0, pc});
      chk("linear_mode", {15'h0, linear}, {15'h0, lin});
   endtask

   task automatic t_defaults();
      for (int n = 1; n <= 4; n++) begin
         por(3'(n));
         rd_chk("vchg_default", cvs_pkg::CMD_MAX_CHARGE_VOLT, VCHG_DEF[n-1]);
         rd_chk("vsys_default", cvs_pkg::CMD_MIN_SYSTEM_VOLT, VSYS_DEF[n-1]);
         chk("vchg_out_default", vchg_mv, VCHG_DEF[n-1]);
         chk("vsys_out_default", vsys_mv, VSYS_DEF[n-1]);
      end
      rd_chk("ichg_default", cvs_pkg::CMD_CHARGE_CURRENT, 16'h0000);
      rd_chk("option_default", cvs_pkg::CMD_CHARGE_OPTION, 16'h0004);
      rd_chk("unmapped", 8'h20, 16'h0000);
      $display("Test defaults done");
   endtask

   task automatic t_ranges();
      for (int i = 0; i < 7; i++) begin
         u_host.wr(cvs_pkg::CMD_MAX_CHARGE_VOLT, VW[i]);
         rd_chk("vchg_write", cvs_pkg::CMD_MAX_CHARGE_VOLT, VE[i]);
         chk("vchg_out", vchg_mv, VE[i]);
      end
      for (int i = 0; i < 5; i++) begin
         u_host.wr(cvs_pkg::CMD_MIN_SYSTEM_VOLT, SW[i]);
         rd_chk("vsys_write", cvs_pkg::CMD_MIN_SYSTEM_VOLT, SE[i]);
         chk("vsys_out", vsys_mv, SE[i]);
      end
      $display("Test ranges done");
   endtask

   task automatic t_current();
      por(3'h2);
      vbat = 16'h2000;
      u_host.wr(cvs_pkg::CMD_CHARGE_CURRENT, 16'h1fff);
      rd_chk("ichg_write", cvs_pkg::CMD_CHARGE_CURRENT, 16'h1fc0);
      cyc(2);
      chk("ichg_out", ichg_ma, 16'h1fc0);
      chk("charge_enable", {15'h0, chg_en}, 16'h0001);
      u_host.wr(cvs_pkg::CMD_CHARGE_CURRENT, 16'h2040);
      rd_chk("ichg_invalid", cvs_pkg::CMD_CHARGE_CURRENT, 16'h1fc0);
      pgood = 1'b0;
      cyc(8);
      chk("enable_power_lost", {15'h0, chg_en}, 16'h0000);
      u_host.wr(cvs_pkg::CMD_CHARGE_CURRENT, 16'h0400);
      cyc(2);
      chk("enable_no_power", {15'h0, chg_en}, 16'h0000);
      chk("ichg_out_no_power", ichg_ma, 16'h0000);
      pgood = 1'b1;
      cyc(8);
      u_host.wr(cvs_pkg::CMD_CHARGE_CURRENT, 16'h1fc0);
      cyc(2);
      chk("enable_power_back", {15'h0, chg_en}, 16'h0001);
      chk("ichg_out_power_back", ichg_ma, 16'h1fc0);
      strap = 3'h0;
      cyc(8);
      chk("ichg_removed_out", ichg_ma, 16'h0000);
      rd_chk("ichg_removed", cvs_pkg::CMD_CHARGE_CURRENT, 16'h0000);
      strap = 3'h2;
      cyc(8);
      u_host.set_charge(16'h3000, 16'h0400);
      u_host.wr(cvs_pkg::CMD_MAX_CHARGE_VOLT, 16'h000f);
      rd_chk("vchg_zero_write", cvs_pkg::CMD_MAX_CHARGE_VOLT, 16'h20d0);
      rd_chk("ichg_after_zero", cvs_pkg::CMD_CHARGE_CURRENT, 16'h0000);
      chk("enable_after_zero", {15'h0, chg_en}, 16'h0000);
      $display("Test current done");
   endtask

   task automatic t_clamps();
      por(3'h2);
      u_host.wr(cvs_pkg::CMD_CHARGE_CURRENT, 16'h1000);
      vbat = 16'h1388;
      flags(16'h0180, 1'b1, 1'b1);
      vbat = 16'h1b58;
      flags(16'h1000, 1'b0, 1'b0);
      u_host.wr(cvs_pkg::CMD_CHARGE_OPTION, 16'h0000);
      rd_chk("option_write", cvs_pkg::CMD_CHARGE_OPTION, 16'h0000);
      vbat = 16'h1388;
      flags(16'h0180, 1'b1, 1'b0);
      por(3'h1);
      u_host.wr(cvs_pkg::CMD_CHARGE_CURRENT, 16'h1000);
      vbat = 16'h09c4;
      flags(16'h0180, 1'b1, 1'b1);
      vbat = 16'h0bb8;
      flags(16'h07d0, 1'b0, 1'b1);
      vbat = 16'h0fa0;
      flags(16'h1000, 1'b0, 1'b0);
      $display("Test clamps done");
   endtask

   // The run needs about 450 cycles; the ceiling leaves ample margin.
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         $display("Error timeout expected finish seen hang");
         test_done();
      end
   end

   initial begin
      por(3'h1);
      t_defaults();
      t_ranges();
      t_current();
      t_clamps();
      test_done();
   end
endmodule // cvs_setpoints_test
